//--- hdl/trig_seq_cfg.svh
// How it works
// - no-operation combination keeps the state index and starts no movement
// - a running movement under no-operation finishes as its state defines
// - next-state combination advances the index by one and runs that state
// - previous-state combination lowers the index by one and runs that state
// - new step during absolute move A: none keeps A, abs B, A+B, curve
// - a combination is acted on only after staying stable for the filter time
`ifndef TRIG_SEQ_CFG_SVH
`define TRIG_SEQ_CFG_SVH

`define TRIG_W     4
`define NUM_COMBOS 16
`define NUM_STATES 8
`define POS_W      16
`define FILT_W     16
`define CMD_W      2
`define KIND_W     2

`endif

//--- hdl/trig_seq_pkg.sv
package trig_seq_pkg;
  // command assigned to a trigger combination; 2'b11 acts as no-operation
  typedef enum logic [1:0] {
    CMD_NOP  = 2'b00,
    CMD_NEXT = 2'b01,
    CMD_PREV = 2'b10,
    CMD_RSVD = 2'b11
  } cmd_e;

  // movement a state defines
  typedef enum logic [1:0] {
    MV_NONE  = 2'b00,
    MV_ABS   = 2'b01,
    MV_REL   = 2'b10,
    MV_CURVE = 2'b11
  } move_kind_e;
endpackage

//--- hdl/trig_if.sv
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"
// filtered trigger combination and its change pulse
interface trig_if;
  logic [`TRIG_W-1:0] combo;
  logic               chg;
  modport src (output combo, output chg);
  modport snk (input combo, input chg);
endinterface

//--- hdl/trig_filter.sv
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"
module trig_filter (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // raw triggers and filter time in cycles
  input  wire logic [`TRIG_W-1:0] trig_i,
  input  wire logic [`FILT_W-1:0] filter_cycles_i,
  // filtered result
  trig_if.src                     tf
);
  logic [`TRIG_W-1:0] raw_reg;
  logic [`TRIG_W-1:0] cand_reg;
  logic [`TRIG_W-1:0] stable_reg;
  logic [`FILT_W-1:0] cnt_reg;
  logic               chg_reg;

  // input register; triggers are taken as synchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) raw_reg <= '0;
    else          raw_reg <= trig_i;
  end

  // any jitter restarts the hold count, so short glitches never pass
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cand_reg <= '0;
      cnt_reg  <= '0;
    end else if (raw_reg != cand_reg) begin
      cand_reg <= raw_reg;
      cnt_reg  <= '0;
    end else if (cnt_reg < filter_cycles_i) begin
      cnt_reg  <= cnt_reg + 1'b1;
    end
  end

  // hand over a new combination once it has been held long enough
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_reg <= '0;
      chg_reg    <= 1'b0;
    end else if (raw_reg == cand_reg && cnt_reg >= filter_cycles_i &&
                 cand_reg != stable_reg) begin
      stable_reg <= cand_reg;
      chg_reg    <= 1'b1;
    end else begin
      chg_reg    <= 1'b0;
    end
  end

  assign tf.combo = stable_reg;
  assign tf.chg   = chg_reg;

  a_filter_hold_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    chg_reg |-> $past(cnt_reg) >= $past(filter_cycles_i))
    else $error("combination passed before the filter time");

  a_filter_real_change: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    chg_reg |-> stable_reg != $past(stable_reg))
    else $error("change pulse without a new combination");
endmodule

//--- hdl/trigger_state_sequencer.sv
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"
module trigger_state_sequencer
  import trig_seq_pkg::*;
#(
  parameter int NSTATES = `NUM_STATES,
  parameter int POS_W   = `POS_W,
  parameter int IDX_W   = $clog2(`NUM_STATES)
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // trigger inputs from the master control
  input  wire logic [`TRIG_W-1:0]         trig_i,
  input  wire logic [`FILT_W-1:0]         filter_cycles_i,
  // configuration: command per combination, movement per state
  input  wire logic [`NUM_COMBOS*`CMD_W-1:0] cmd_tab_i,
  input  wire logic [NSTATES*`KIND_W-1:0] kind_tab_i,
  input  wire logic [NSTATES*POS_W-1:0]   val_tab_i,
  // motion status from the servo loop
  input  wire logic                       busy_i,
  input  wire logic [POS_W-1:0]           pos_i,
  // resulting movement
  output logic [IDX_W-1:0]                state_idx_o,
  output move_kind_e                      move_kind_o,
  output logic [POS_W-1:0]                move_target_o,
  output logic                            move_start_o,
  output logic [`TRIG_W-1:0]              combo_o
);
  trig_if tf ();

  // the master selects commands through this filter only
  trig_filter u_filter (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .trig_i          (trig_i),
    .filter_cycles_i (filter_cycles_i),
    .tf              (tf)
  );

  cmd_e             cmd;
  logic [IDX_W-1:0] idx_next;
  move_kind_e       new_kind;
  logic [POS_W-1:0] new_val;
  logic [POS_W-1:0] rel_base;

  // decode the command and the state it lands on
  always_comb begin
    cmd      = cmd_e'(cmd_tab_i[tf.combo*`CMD_W +: `CMD_W]);
    idx_next = state_idx_o;
    unique case (cmd)
      CMD_NEXT: idx_next = (state_idx_o == IDX_W'(NSTATES-1)) ? '0
                           : state_idx_o + 1'b1;
      CMD_PREV: idx_next = (state_idx_o == '0) ? IDX_W'(NSTATES-1)
                           : state_idx_o - 1'b1;
      CMD_NOP, CMD_RSVD: idx_next = state_idx_o;
    endcase
    new_kind = move_kind_e'(kind_tab_i[idx_next*`KIND_W +: `KIND_W]);
    new_val  = val_tab_i[idx_next*POS_W +: POS_W];
  end

  // relative step on a running absolute move adds to its target; on a
  // running curve or when idle it adds to the present demand position
  always_comb begin
    if (busy_i && move_kind_o == MV_ABS) rel_base = move_target_o;
    else                                 rel_base = pos_i;
  end

  logic act;
  assign act = tf.chg && cmd != CMD_NOP && cmd != CMD_RSVD;

  // state index moves only on an accepted step command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) state_idx_o <= '0;
    else if (act) state_idx_o <= idx_next;
  end

  // movement combination; an empty state leaves the running move alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      move_kind_o   <= MV_NONE;
      move_target_o <= '0;
      move_start_o  <= 1'b0;
    end else begin
      move_start_o <= 1'b0;
      if (act && new_kind != MV_NONE) begin
        move_kind_o  <= new_kind;
        move_start_o <= 1'b1;
        unique case (new_kind)
          MV_REL:   move_target_o <= rel_base + new_val;
          MV_ABS, MV_CURVE: move_target_o <= new_val;
          MV_NONE:  move_target_o <= move_target_o;
        endcase
      end
    end
  end

  // filtered combination for observation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) combo_o <= '0;
    else          combo_o <= tf.combo;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_nop_cmd;
    tf.chg && (cmd == CMD_NOP || cmd == CMD_RSVD);
  endsequence
  sequence s_step(cmd_e c);
    tf.chg && cmd == c;
  endsequence

  a_nop_keeps_idx: assert property (s_nop_cmd |=>
    $stable(state_idx_o) && !move_start_o)
    else $error("no-operation changed index or started a move");
  a_nop_keeps_move: assert property (s_nop_cmd |=>
    $stable(move_target_o) && $stable(move_kind_o))
    else $error("no-operation disturbed the running move");
  a_next_step_up: assert property (s_step(CMD_NEXT) |=>
    state_idx_o == (($past(state_idx_o) == IDX_W'(NSTATES-1)) ? '0
                    : $past(state_idx_o) + 1'b1))
    else $error("next-state did not advance by one");
  a_prev_step_down: assert property (s_step(CMD_PREV) |=>
    state_idx_o == (($past(state_idx_o) == '0) ? IDX_W'(NSTATES-1)
                    : $past(state_idx_o) - 1'b1))
    else $error("previous-state did not step back by one");
  a_abs_replace: assert property (act && new_kind == MV_ABS |=>
    move_start_o && move_kind_o == MV_ABS
    && move_target_o == $past(new_val))
    else $error("absolute step did not replace target");
  a_rel_on_abs: assert property (act && new_kind == MV_REL && busy_i
    && move_kind_o == MV_ABS |=>
    move_target_o == POS_W'($past(move_target_o) + $past(new_val)))
    else $error("relative step on absolute move not A plus B");
  a_quiet_hold: assert property (!tf.chg |=>
    $stable(state_idx_o) && !move_start_o)
    else $error("command acted without a combination change");
  a_start_pulse: assert property (move_start_o |=> !move_start_o)
    else $error("start pulse longer than one cycle");

  // accepted step towards a state of a given movement kind
  sequence s_act_kind(move_kind_e k);
    act && new_kind == k;
  endsequence

  // a curve replaces whatever movement was running
  a_curve_replace: assert property (s_act_kind(MV_CURVE) |=>
    move_start_o && move_kind_o == MV_CURVE
    && move_target_o == $past(new_val))
    else $error("curve step did not replace the move");

  // relative step when idle or after a curve adds to the position
  a_rel_on_pos: assert property (s_act_kind(MV_REL) ##0
    !(busy_i && move_kind_o == MV_ABS) |=>
    move_target_o == POS_W'($past(pos_i) + $past(new_val)))
    else $error("relative step not added to the position");

  // an empty state moves the index but leaves the running move alone
  a_empty_state: assert property (s_act_kind(MV_NONE) |=>
    !move_start_o && $stable(move_target_o) && $stable(move_kind_o))
    else $error("empty state disturbed the running move");

  // a step onto a state with a movement starts it
  a_step_starts: assert property (act && new_kind != MV_NONE |=>
    move_start_o)
    else $error("step onto a movement state gave no start");

  // a start pulse always traces back to an accepted step
  a_start_cause: assert property (move_start_o |-> $past(act))
    else $error("start pulse without an accepted step");

  // an accepted step lands exactly on the decoded index
  a_idx_follows: assert property (act |=>
    state_idx_o == $past(idx_next))
    else $error("index did not take the decoded value");

  // next-state from the last index wraps to the first
  a_next_wrap: assert property (s_step(CMD_NEXT) ##0
    state_idx_o == IDX_W'(NSTATES-1) |=> state_idx_o == '0)
    else $error("next-state did not wrap to the first index");

  // previous-state from the first index wraps to the last
  a_prev_wrap: assert property (s_step(CMD_PREV) ##0
    state_idx_o == '0 |=> state_idx_o == IDX_W'(NSTATES-1))
    else $error("previous-state did not wrap to the last index");

  // the spare command code behaves as no-operation
  a_rsvd_as_nop: assert property (s_step(CMD_RSVD) |=>
    $stable(state_idx_o) && !move_start_o)
    else $error("spare command code acted like a step");

  // between starts the commanded movement never drifts
  a_move_holds: assert property (!move_start_o |->
    $stable(move_kind_o) && $stable(move_target_o))
    else $error("movement changed without a start pulse");

  // a start never announces an empty movement
  a_start_kind: assert property (move_start_o |->
    move_kind_o != MV_NONE)
    else $error("start pulse with no movement kind");

  // the change pulse lasts one cycle, so a held combination acts once
  a_chg_single: assert property (tf.chg |=> !tf.chg)
    else $error("change pulse longer than one cycle");

  // observed combination trails the filtered one by one cycle
  a_combo_follows: assert property (1'b1 |=>
    combo_o == $past(tf.combo))
    else $error("observed combination does not follow the filter");
endmodule

//--- verification/trig_master.sv
`timescale 1ns/1ps
// master control: drives one combination on the four trigger inputs
module trig_master (
  // clock
  input  wire logic       clk_i,
  // trigger combination towards the device
  output logic      [3:0] trig_o
);
  // idle combination is the no-operation one, so reset sees no change
  initial trig_o = 4'h0;

  // a new combination is placed just after an edge and then held
  task automatic drive(input logic [3:0] c);
    @(posedge clk_i);
    #1 trig_o = c;
  endtask
endmodule

//--- verification/trigger_state_sequencer_test.sv
`timescale 1ns/1ps
module trigger_state_sequencer_test;
  import trig_seq_pkg::*;
  logic         clk_i, rst_n_i, busy, start;
  logic [3:0]   trig, combo, cur, nxt;
  logic [15:0]  filt, kind_tab, pos, tgt_o, tgt;
  logic [31:0]  cmd_tab;
  logic [127:0] val_tab;
  logic [2:0]   idx_o, idx;
  move_kind_e   kind_o, ekind;
  int           errors, n_tests, pulses;

  trig_master m (.clk_i(clk_i), .trig_o(trig));
  trigger_state_sequencer trigger_state_sequencer_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .trig_i(trig),
    .filter_cycles_i(filt), .cmd_tab_i(cmd_tab), .kind_tab_i(kind_tab),
    .val_tab_i(val_tab), .busy_i(busy), .pos_i(pos),
    .state_idx_o(idx_o), .move_kind_o(kind_o), .move_target_o(tgt_o),
    .move_start_o(start), .combo_o(combo));

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // count start pulses; a held combination must not add a second one
  always @(posedge clk_i) if (start === 1'b1) pulses <= pulses + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // apply a combination, wait past filter plus latency, then compare
  task automatic step(input logic [3:0] c);
    logic [1:0]  k;
    logic [15:0] v;
    logic        go;
    pulses = 0;
    m.drive(c);
    repeat (filt + 8) @(posedge clk_i);
    #1;
    if (c == 4'h1) idx = idx + 3'h1;
    if (c == 4'h2) idx = idx - 3'h1;
    k = kind_tab[idx*2+:2];
    v = val_tab[idx*16+:16];
    go = (c == 4'h1 || c == 4'h2) && k != MV_NONE;
    // relative adds to a running absolute target, else to the position
    if (go) begin
      if (k == MV_REL) tgt = ((busy && ekind == MV_ABS) ? tgt : pos) + v;
      else tgt = v;
      ekind = move_kind_e'(k);
    end
    cur = c;
    check(16'(idx_o), 16'(idx));
    check(16'(pulses), 16'(go));
    check(16'(kind_o), 16'(ekind));
    check(tgt_o, tgt);
    check(16'(combo), 16'(c));
  endtask

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    {filt, kind_tab, val_tab, busy, pos} = '0;
    {errors, n_tests, pulses, idx, tgt, cur} = '0;
    ekind = MV_NONE;
    void'($urandom(32'hd617));
    cmd_tab = {24'($urandom()), 8'he4}; // combos 0..3: nop next prev rsvd
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    check(16'(idx_o), 16'h0000);
    check(16'(start), 16'h0000);
    kind_tab = 16'($urandom());
    val_tab = {$urandom(), $urandom(), $urandom(), $urandom()};
    step(4'h2);
    // short glitch under a long filter must be ignored
    filt = 16'h0004;
    pulses = 0;
    m.drive(4'h1);
    m.drive(4'h2);
    repeat (14) @(posedge clk_i);
    #1;
    check(16'(idx_o), 16'h0007);
    check(16'(pulses), 16'h0000);
    check(16'(combo), 16'h0002);
    repeat (40) begin
      do nxt = 4'($urandom() % 4); while (nxt == cur);
      kind_tab = 16'($urandom());
      val_tab = {$urandom(), $urandom(), $urandom(), $urandom()};
      busy = 1'($urandom());
      pos = 16'($urandom());
      filt = 16'($urandom() % 4);
      step(nxt);
    end
    stop_test;
  end

  // watchdog
  initial begin
    #200000;
    errors++;
    stop_test;
  end
endmodule
